//--- shbp_pkg.sv
// shbp_pkg: constants shared by both ends of the sram-like host bus port.
// assumes a single 50 MHz clock on both ends.
package shbp_pkg;

    // ****************
    // widths and map
    // ****************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int LEN_W = 8;
    localparam int BURST_MAX = 16;
    localparam logic [ADDR_W-1:0] RXD_BASE = 7'h00;
    localparam logic [ADDR_W-1:0] TXD_BASE = 7'h10;
    localparam logic [ADDR_W-1:0] PORT_MASK = 7'h7C;
    localparam logic [DATA_W-1:0] BUS_IDLE = 16'hFFFF;

    // ****************
    // timing
    // ****************
    localparam int CLK_NS = 20;
    localparam int T_CYCLE_NS = 165;
    localparam int T_CSL_NS = 32;
    localparam int T_CSH_NS = 13;
    localparam int T_ACYC_NS = 165;
    localparam int T_ADV_NS = 40;
    localparam int T_RAW_NS = 330;
    localparam int T_TURN_NS = 80;
    localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSL_CYC = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSH_CYC = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACYC_CYC = (T_ACYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADV_CYC = T_ADV_NS / CLK_NS;
    localparam int RAW_CYC = (T_RAW_NS + CLK_NS - 1) / CLK_NS;
    localparam int TURN_CYC = (T_TURN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ASSERT_CYC = (CYCLE_CYC - CSH_CYC > CSL_CYC) ?
        CYCLE_CYC - CSH_CYC : CSL_CYC;

    typedef logic [ADDR_W-1:0] shbp_addr_t;
    typedef logic [DATA_W-1:0] shbp_data_t;

endpackage : shbp_pkg

//--- shbp_bus_if.sv
// shbp_bus_if: the pins between host and device.
// assumes the data wire has a pull-up; the device end wins any overlap.
`timescale 1ns/1ns
interface shbp_bus_if;
    import shbp_pkg::*;
    logic chip_sel_l;
    logic read_strobe_l;
    logic write_strobe_l;
    logic fifo_sel;
    shbp_addr_t addr;
    shbp_data_t host_d;
    logic host_d_oe_l;
    shbp_data_t dev_d;
    logic dev_d_oe_l;
    shbp_data_t data;

    // ****************
    // wire level
    // ****************
    assign data = !dev_d_oe_l ? dev_d : (!host_d_oe_l ? host_d : BUS_IDLE);

    modport host (
        output chip_sel_l, read_strobe_l, write_strobe_l, fifo_sel, addr,
        output host_d, host_d_oe_l,
        input data
    );
    modport dev (
        input chip_sel_l, read_strobe_l, write_strobe_l, fifo_sel, addr,
        output dev_d, dev_d_oe_l,
        input data
    );
endinterface : shbp_bus_if

//--- shbp_host.sv
// shbp_host: host end; turns single or burst requests into strobe cycles.
// assumes one request at a time, taken while ready_o is high.
`timescale 1ns/1ns
module shbp_host (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    shbp_bus_if.host bus,
    input wire logic req_i,
    input wire logic req_wr_i,
    input wire logic req_fsel_i,
    input wire shbp_pkg::shbp_addr_t req_addr_i,
    input wire shbp_pkg::shbp_data_t req_data_i,
    input wire logic [shbp_pkg::LEN_W-1:0] req_len_i,
    output logic ready_o,
    output logic rd_valid_o,
    output shbp_pkg::shbp_data_t rd_data_o,
    output logic done_o
);
    import shbp_pkg::*;

    typedef enum logic [3:0] {
        SH_IDLE = 4'b0001,
        SH_ASSERT = 4'b0010,
        SH_RELEASE = 4'b0100,
        SH_GAP = 4'b1000
    } shbp_hstate_t;

    shbp_hstate_t state;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] words;
    logic is_wr;
    shbp_data_t d_m;
    shbp_data_t d_s;

    wire logic take = req_i && ready_o;
    wire logic word_end = (state == SH_ASSERT) && (cnt == LEN_W'(ACYC_CYC - 1));
    wire logic last_word = (words == '0);
    wire logic [LEN_W-1:0] len_cap = (!req_fsel_i && req_len_i > LEN_W'(BURST_MAX - 1)) ?
        LEN_W'(BURST_MAX - 1) : req_len_i;

    // ****************
    // data pin sampling
    // ****************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            d_m <= '0;
            d_s <= '0;
        end else if (ce_i) begin
            d_m <= bus.data;
            d_s <= d_m;
        end
    end

    // ****************
    // cycle sequencer
    // ****************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= SH_IDLE;
            cnt <= '0;
            words <= '0;
            is_wr <= 1'b0;
            ready_o <= 1'b1;
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
            done_o <= 1'b0;
            bus.chip_sel_l <= 1'b1;
            bus.read_strobe_l <= 1'b1;
            bus.write_strobe_l <= 1'b1;
            bus.fifo_sel <= 1'b0;
            bus.addr <= '0;
            bus.host_d <= '0;
            bus.host_d_oe_l <= 1'b1;
        end else if (ce_i) begin
            rd_valid_o <= 1'b0;
            done_o <= 1'b0;
            cnt <= LEN_W'(cnt + 1'b1);
            unique case (state)
                SH_IDLE: begin
                    if (take) begin
                        state <= SH_ASSERT;
                        cnt <= '0;
                        ready_o <= 1'b0;
                        is_wr <= req_wr_i;
                        words <= req_wr_i ? '0 : len_cap;
                        bus.chip_sel_l <= 1'b0;
                        bus.read_strobe_l <= req_wr_i;
                        bus.write_strobe_l <= !req_wr_i;
                        bus.fifo_sel <= req_fsel_i;
                        bus.addr <= req_addr_i;
                        bus.host_d <= req_data_i;
                        bus.host_d_oe_l <= !req_wr_i;
                    end
                end
                SH_ASSERT: begin
                    if (word_end) begin
                        cnt <= '0;
                        if (!is_wr) begin
                            rd_valid_o <= 1'b1;
                            rd_data_o <= d_s;
                        end
                        if (last_word) begin
                            state <= SH_RELEASE;
                            bus.chip_sel_l <= 1'b1;
                            bus.read_strobe_l <= 1'b1;
                            bus.write_strobe_l <= 1'b1;
                        end else begin
                            words <= LEN_W'(words - 1'b1);
                            bus.addr <= shbp_addr_t'(bus.addr + 1'b1);
                        end
                    end
                end
                SH_RELEASE: begin
                    bus.host_d_oe_l <= 1'b1;
                    if (cnt == LEN_W'(CSH_CYC - 1)) begin
                        state <= SH_GAP;
                        cnt <= '0;
                    end
                end
                SH_GAP: begin
                    if (cnt == LEN_W'((is_wr ? RAW_CYC : TURN_CYC) - 1)) begin
                        state <= SH_IDLE;
                        ready_o <= 1'b1;
                        done_o <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule : shbp_host

//--- shbp_dev.sv
// shbp_dev: device end of the sram-like host bus port.
// assumes register and fifo logic on mclk_i answering rd_data_i combinationally
// from rd_addr_o; host pins are asynchronous and are synchronised here.
// the host must keep a read's strobes low long enough for the late answer.
`timescale 1ns/1ns

module shbp_dev (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    shbp_bus_if.dev bus,
    output logic rd_start_o,
    output shbp_pkg::shbp_addr_t rd_addr_o,
    input wire shbp_pkg::shbp_data_t rd_data_i,
    output logic rd_done_o,
    output logic rx_pop_o,
    output logic wr_o,
    output shbp_pkg::shbp_addr_t wr_addr_o,
    output shbp_pkg::shbp_data_t wr_data_o,
    output logic tx_push_o
);
    import shbp_pkg::*;

    localparam int SYNC_W = 4 + ADDR_W + DATA_W;

    typedef enum logic [2:0] {
        SD_IDLE = 3'b001,
        SD_READ = 3'b010,
        SD_WRITE = 3'b100
    } shbp_dstate_t;

    // ****************
    // helpers
    // ****************
    // fifo direct decode
    function automatic shbp_addr_t eff_addr(input logic fsel, input shbp_addr_t a,
                                            input shbp_addr_t base);
        eff_addr = fsel ? ((base & PORT_MASK) | (a & ~PORT_MASK)) : a;
    endfunction : eff_addr

    function automatic logic in_port(input shbp_addr_t a, input shbp_addr_t base);
        in_port = ((a & PORT_MASK) == base);
    endfunction : in_port

    shbp_dstate_t state;
    logic [SYNC_W-1:0] pin_m;
    logic [SYNC_W-1:0] pin_s;
    shbp_addr_t raw_addr;
    shbp_data_t wdata;

    wire logic cs_l = pin_s[SYNC_W-1];
    wire logic rd_l = pin_s[SYNC_W-2];
    wire logic wr_l = pin_s[SYNC_W-3];
    wire logic fsel = pin_s[SYNC_W-4];
    wire shbp_addr_t addr_s = pin_s[DATA_W +: ADDR_W];
    wire shbp_data_t data_s = pin_s[DATA_W-1:0];
    wire logic rd_act = !cs_l && !rd_l;
    wire logic wr_act = !cs_l && !wr_l;
    wire shbp_addr_t rd_eff = eff_addr(fsel, addr_s, RXD_BASE);
    wire shbp_addr_t wr_eff = eff_addr(fsel, addr_s, TXD_BASE);
    // new burst word on address change
    wire logic new_word = (state == SD_READ) && rd_act && (addr_s != raw_addr);
    wire logic rd_end = (state == SD_READ) && !rd_act;
    wire logic word_done = new_word || rd_end;
    wire logic rd_begin = (state == SD_IDLE) && rd_act;
    // pins driven only inside a read
    wire logic dev_drive = (state == SD_READ) && rd_act;
    // write ends on the first edge that sees the release
    wire logic wr_end = (state == SD_WRITE) && !wr_act;

    // ****************
    // pin synchroniser
    // ****************
    // fifo select sampled with address
    // all pins pass the same two stages, so they stay aligned
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_m <= '1;
            pin_s <= '1;
        end else if (ce_i) begin
            pin_m <= {bus.chip_sel_l, bus.read_strobe_l, bus.write_strobe_l,
                      bus.fifo_sel, bus.addr, bus.data};
            pin_s <= pin_m;
        end
    end

    // ****************
    // cycle tracker
    // ****************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= SD_IDLE;
        end else if (ce_i) begin
            unique case (state)
                SD_IDLE: begin
                    if (rd_act) begin
                        state <= SD_READ;
                    end else if (wr_act) begin
                        state <= SD_WRITE;
                    end
                end
                SD_READ: begin
                    if (!rd_act) begin
                        state <= SD_IDLE;
                    end
                end
                SD_WRITE: begin
                    if (!wr_act) begin
                        state <= SD_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************
    // burst word tracker
    // ****************
    // address kept one edge back so a burst step shows as a change
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            raw_addr <= '0;
        end else if (ce_i) begin
            raw_addr <= addr_s;
        end
    end

    // ****************
    // write capture
    // ****************
    // last data seen before release
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wdata <= '0;
            wr_addr_o <= '0;
        end else if (ce_i && wr_act && (state == SD_WRITE)) begin
            wdata <= data_s;
            wr_addr_o <= wr_eff;
        end
    end

    // ****************
    // read side
    // ****************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rd_start_o <= 1'b0;
            rd_addr_o <= '0;
            rd_done_o <= 1'b0;
            rx_pop_o <= 1'b0;
            bus.dev_d <= '0;
            bus.dev_d_oe_l <= 1'b1;
        end else if (ce_i) begin
            rd_start_o <= rd_begin;
            rd_done_o <= word_done;
            // rd_addr_o still names the word just finished on this edge
            rx_pop_o <= word_done && in_port(rd_addr_o, RXD_BASE);
            if (rd_act) begin
                rd_addr_o <= rd_eff;
            end
            bus.dev_d_oe_l <= !dev_drive;
            bus.dev_d <= rd_data_i;
        end
    end

    // ****************
    // write side
    // ****************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_o <= 1'b0;
            wr_data_o <= '0;
            tx_push_o <= 1'b0;
        end else if (ce_i) begin
            wr_o <= wr_end;
            tx_push_o <= wr_end && in_port(wr_addr_o, TXD_BASE);
            if (wr_end) begin
                wr_data_o <= wdata;
            end
        end
    end

endmodule : shbp_dev

//--- shbp_props.sv
// shbp_props: timing checks on the pins between host and device ends.
// assumes the pins of one shbp_bus_if instance and the shared clock.
`timescale 1ns/1ns
module shbp_props
    import shbp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic chip_sel_l,
    input wire logic read_strobe_l,
    input wire logic write_strobe_l,
    input wire logic fifo_sel,
    input wire shbp_addr_t addr,
    input wire shbp_data_t host_d,
    input wire logic host_d_oe_l,
    input wire logic dev_d_oe_l
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************
    // helper counts
    // ****************
    logic [5:0] since_wr;
    logic [7:0] burst_words;
    shbp_addr_t prev_addr;
    wire rd_act = !chip_sel_l && !read_strobe_l;
    always_ff @(posedge mclk_i) begin
        prev_addr <= addr;
        if (!rst_n_i) since_wr <= 6'h3F;
        else if (!write_strobe_l) since_wr <= 6'h00;
        else if (since_wr != 6'h3F) since_wr <= since_wr + 6'h01;
        if (!rst_n_i || !rd_act) burst_words <= 8'h00;
        else if (addr != prev_addr) burst_words <= burst_words + 8'h01;
    end
    chk_drive_on_read: assert property (
        $fell(dev_d_oe_l) |-> $past(rd_act, 3) && rd_act)
        else $error("device drove data outside a read");
    chk_release_bus: assert property (!rd_act [*6] |-> dev_d_oe_l)
        else $error("device kept driving after read end");
    chk_no_clash: assert property (!write_strobe_l |-> dev_d_oe_l)
        else $error("device drove data during a write");
    chk_strobes_excl: assert property (read_strobe_l || write_strobe_l)
        else $error("read and write strobes low together");
    chk_idle_gap: assert property ($rose(chip_sel_l) |-> chip_sel_l [*2])
        else $error("select high time too short");
    chk_assert_len: assert property ($fell(chip_sel_l) |-> !chip_sel_l [*8])
        else $error("select low time too short");
    chk_write_hold: assert property (
        !write_strobe_l && !$past(write_strobe_l) |->
        $stable(host_d) && $stable(addr) && $stable(fifo_sel) && !host_d_oe_l)
        else $error("write data or address moved in a write");
    chk_write_space: assert property ($fell(read_strobe_l) |-> since_wr >= RAW_CYC)
        else $error("read too soon after write");
    chk_burst_limit: assert property (rd_act && !fifo_sel |-> burst_words <= BURST_MAX)
        else $error("normal burst too long");
endmodule : shbp_props

//--- sram_like_host_bus_port_tb_top.sv
// sram_like_host_bus_port_tb_top: host end and device end joined by the bus.
// assumes a combinational register answer built by the bench from rd_addr_o.
`timescale 1ns/1ns
module sram_like_host_bus_port_tb_top;
    import shbp_pkg::*;
    logic mclk_i, rst_n_i, ce_i, req_i, req_wr_i, req_fsel_i;
    shbp_addr_t req_addr_i, rd_addr_o, wr_addr_o;
    shbp_data_t req_data_i, rd_data_o, rd_data_i, wr_data_o;
    logic [LEN_W-1:0] req_len_i;
    logic ready_o, rd_valid_o, done_o, rd_start_o, rd_done_o, rx_pop_o, wr_o, tx_push_o;
    int bad_count, num_checks, cycles, cnt_rd, cnt_pop, cnt_start, cnt_wr;
    logic [31:0] seed, r;
    shbp_bus_if shbp_bus_if_inst ();
    shbp_host shbp_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .bus(shbp_bus_if_inst), .req_i(req_i), .req_wr_i(req_wr_i), .req_fsel_i(req_fsel_i),
        .req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_len_i(req_len_i),
        .ready_o(ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o));
    shbp_dev shbp_dev_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .bus(shbp_bus_if_inst), .rd_start_o(rd_start_o), .rd_addr_o(rd_addr_o),
        .rd_data_i(rd_data_i), .rd_done_o(rd_done_o), .rx_pop_o(rx_pop_o), .wr_o(wr_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .tx_push_o(tx_push_o));
    shbp_props shbp_props_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .chip_sel_l(shbp_bus_if_inst.chip_sel_l), .read_strobe_l(shbp_bus_if_inst.read_strobe_l),
        .write_strobe_l(shbp_bus_if_inst.write_strobe_l), .fifo_sel(shbp_bus_if_inst.fifo_sel),
        .addr(shbp_bus_if_inst.addr), .host_d(shbp_bus_if_inst.host_d),
        .host_d_oe_l(shbp_bus_if_inst.host_d_oe_l), .dev_d_oe_l(shbp_bus_if_inst.dev_d_oe_l));
    // ****************
    // expectations
    // ****************
    function automatic shbp_addr_t eff_addr(input logic fs, input logic wr, input shbp_addr_t a);
        shbp_addr_t base;
        base = wr ? TXD_BASE : RXD_BASE;
        return fs ? {base[6:2], a[1:0]} : a;
    endfunction : eff_addr
    function automatic shbp_data_t word_of(input shbp_addr_t a);
        return {~a, 2'b10, a};
    endfunction : word_of
    function automatic logic to_tx(input logic fs, input shbp_addr_t a);
        return (eff_addr(fs, 1'b1, a) >> 2) == (TXD_BASE >> 2);
    endfunction : to_tx
    assign rd_data_i = word_of(rd_addr_o);
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic run_req(input logic wr, input logic fs, input shbp_addr_t a,
                           input shbp_data_t d, input logic [LEN_W-1:0] len);
        int n, pops, words;
        shbp_addr_t ea;
        n = wr ? 1 : int'(len) + 1;
        if (!fs && n > BURST_MAX) n = BURST_MAX;
        pops = 0;
        words = 0;
        for (int i = 0; i < n; i++) begin
            ea = eff_addr(fs, 1'b0, shbp_addr_t'(a + i));
            if (ea[6:2] == RXD_BASE[6:2]) pops++;
        end
        while (ready_o !== 1'b1) @(negedge mclk_i);
        {req_wr_i, req_fsel_i, req_addr_i, req_data_i, req_len_i} = {wr, fs, a, d, len};
        req_i = 1'b1;
        {cnt_rd, cnt_pop, cnt_start, cnt_wr} = '0;
        @(negedge mclk_i);
        req_i = 1'b0;
        while (done_o !== 1'b1) begin
            if (rd_valid_o === 1'b1) begin
                ea = eff_addr(fs, 1'b0, shbp_addr_t'(a + words));
                check(rd_data_o === word_of(ea), "read word");
                words++;
            end
            @(negedge mclk_i);
        end
        if (wr) begin
            check(cnt_wr == 1 && cnt_rd == 0, "write count");
        end else begin
            check(words == n && cnt_rd == n, "read word count");
            check(cnt_pop == pops, "rx pop count");
            check(cnt_start == 1 && cnt_wr == 0, "snapshot count");
        end
    endtask : run_req
    // ****************
    // device side watch
    // ****************
    always @(negedge mclk_i) begin
        if (rd_done_o === 1'b1) cnt_rd++;
        if (rx_pop_o === 1'b1) cnt_pop++;
        if (rd_start_o === 1'b1) begin
            cnt_start++;
            check(rd_addr_o === eff_addr(req_fsel_i, 1'b0, req_addr_i), "read address");
        end
        if (wr_o === 1'b1) begin
            cnt_wr++;
            check(wr_addr_o === eff_addr(req_fsel_i, 1'b1, req_addr_i), "write address");
            check(wr_data_o === req_data_i, "write data");
            check(tx_push_o === to_tx(req_fsel_i, req_addr_i), "tx push");
        end
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial begin
        {rst_n_i, req_i, req_wr_i, req_fsel_i, req_addr_i, req_data_i, req_len_i} = '0;
        {bad_count, num_checks, cycles} = '0;
        ce_i = 1'b1;
        seed = 32'hB00B0CD3;
        repeat (3) @(negedge mclk_i);
        rst_n_i = 1'b1;
        run_req(1'b0, 1'b0, 7'h00, 16'h0000, 8'h0F);
        run_req(1'b0, 1'b1, 7'h7C, 16'h0000, 8'h27);
        run_req(1'b1, 1'b1, 7'h5B, 16'hA5C3, 8'h00);
        run_req(1'b1, 1'b0, 7'h12, 16'h0F0F, 8'h00);
        run_req(1'b0, 1'b0, 7'h11, 16'h0000, 8'h00);
        run_req(1'b0, 1'b1, 7'h3A, 16'h0000, 8'h00);
        run_req(1'b0, 1'b0, 7'h40, 16'h0000, 8'h2C);
        // frozen ends must not start a cycle
        ce_i = 1'b0;
        req_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        check(ready_o === 1'b1 && shbp_bus_if_inst.chip_sel_l === 1'b1, "frozen start");
        req_i = 1'b0;
        ce_i = 1'b1;
        @(negedge mclk_i);
        repeat (40) begin
            r = $random(seed);
            run_req(r[0], r[1], r[8:2], r[31:16], {3'h0, r[13:9]});
        end
        give_verdict();
    end
endmodule : sram_like_host_bus_port_tb_top
